// *** shared/cc_chain_map.svh ***
// register map, field positions, reset values and timing counts of the chaining block
`ifndef CC_CHAIN_MAP_SVH
`define CC_CHAIN_MAP_SVH
`define CC_CFG_OFS       8'h00
`define CC_FIRST_SETUP_REGISTER_OFS    8'h04
`define CC_NID_OFS       8'h08
`define CC_CMD_OFS       8'h0C
`define CC_STAT_OFS      8'h10
`define CC_IMASK_OFS     8'h14
`define CC_CFG_SRST      7
`define CC_CFG_CHAIN     6
`define CC_CFG_TXEN      5
`define CC_FIRST_SETUP_REGISTER_SPEED  0
`define CC_CFG_RST       8'h00
`define CC_FIRST_SETUP_REGISTER_RST    8'h00
`define CC_IMASK_RST     2'h0
`define CC_CHECK_PATTERN 8'hD1
`define CC_GAP_NS        200
`define CC_CLK_NS        5
`define CC_GAP_CYC       ((`CC_GAP_NS + `CC_CLK_NS - 1) / `CC_CLK_NS)
`define CC_HWRST_CYC     5
`endif

// *** shared/cc_pkg.sv ***
// types shared by the chaining block
package cc_pkg;
	typedef enum logic [2:0] {
		CC_CMD_NONE   = 3'h0,
		CC_CMD_DIS_TX = 3'h1,
		CC_CMD_DIS_RX = 3'h2,
		CC_CMD_EN_TX  = 3'h3,
		CC_CMD_EN_RX  = 3'h4,
		CC_CMD_CLR_TX = 3'h5,
		CC_CMD_CLR_RX = 3'h6
	} cc_cmd_e;
	typedef enum logic [1:0] {
		CC_RAM_IDLE = 2'h0,
		CC_RAM_WR0  = 2'h1,
		CC_RAM_WR1  = 2'h2
	} cc_ram_e;
	typedef struct packed {
		logic token_rx;
		logic tx_done;
		logic tx_ack;
		logic rx_start;
		logic rx_done;
	} cc_media_s;
endpackage : cc_pkg

// *** hdl/cc_rst_filter.sv ***
// glitch filter for the hardware reset pin
`timescale 1ns/1ps
`default_nettype none
`include "cc_chain_map.svh"
module cc_rst_filter (
	// clock and bus reset
	input  wire logic pclk,
	input  wire logic presetn,
	// reset pin and filtered result
	input  wire logic hw_reset_n_input,
	output var  logic hw_rst_reg
);
	logic       s1_reg;
	logic       s2_reg;
	logic [2:0] cnt_reg;
	logic       held;
	assign held = (cnt_reg == 3'(`CC_HWRST_CYC - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
		end else begin
			s1_reg <= hw_reset_n_input;
			s2_reg <= s1_reg;
		end
	end
	// short lows restart the count, so glitches never reach the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg    <= 3'h0;
			hw_rst_reg <= 1'b0;
		end else if (s2_reg) begin
			cnt_reg    <= 3'h0;
			hw_rst_reg <= 1'b0;
		end else if (held) begin
			hw_rst_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end
endmodule : cc_rst_filter
`default_nettype wire

// *** hdl/cc_chain.sv ***
// command chaining, status double buffering, interrupt and reset logic
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cc_chain_map.svh"
module cc_chain (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              hw_reset_n_input,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// media engine
	input  wire cc_pkg::cc_media_s media,
	output var  logic              tx_start,
	output var  logic [2:0]        tx_page,
	output var  logic              rx_arm,
	output var  logic [2:0]        rx_page,
	output var  logic              tx_enable,
	output var  logic              core_awake,
	// buffer ram write port
	output var  logic              ram_we,
	output var  logic [10:0]       ram_addr,
	output var  logic [7:0]        ram_wdata,
	// interrupt
	output var  logic              irq
);
	logic        hw_rst;
	logic        core_rst;
	logic [7:0]  cfg_reg, first_setup_register_reg, nid_reg;
	logic [1:0]  imask_reg;
	logic        wr, rd_ok, mapped;
	logic [31:0] rd_data;
	logic        chain, speed;
	logic        cmd_wr;
	logic [2:0]  cmd_page;
	logic        c_dis_tx, c_dis_rx, c_en_tx, c_en_rx, c_clr_tx, c_clr_rx;
	logic [1:0]  txq_v_reg, txq_v_next, rxq_v_reg, rxq_v_next;
	logic [2:0]  txq_p_reg [2], txq_p_next [2], rxq_p_reg [2], rxq_p_next [2];
	logic        tx_act_reg, tx_act_next, rx_busy_reg, rx_busy_next;
	logic [1:0]  txr_v_reg, txr_v_next, txr_a_reg, txr_a_next, rxr_v_reg, rxr_v_next;
	logic [2:0]  rxr_p_reg [2], rxr_p_next [2];
	logic        ta_reg, tma_reg, tma_next;
	logic        tx_start_next, tx_go, rx_go, tx_fin, rx_fin;
	logic        pend, irq_next;
	logic [6:0]  gap_reg;
	logic [6:0]  gap_load;
	cc_pkg::cc_ram_e ram_st_reg, ram_st_next;
	logic        nid_wr;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || core_rst);

	cc_rst_filter u_filt (
		.pclk             (pclk),
		.presetn          (presetn),
		.hw_reset_n_input (hw_reset_n_input),
		.hw_rst_reg       (hw_rst)
	);

	// bus decode; answer comes in the first cycle of the access phase, with no wait state
	assign wr      = psel & penable & pready & pwrite;
	assign chain   = cfg_reg[`CC_CFG_CHAIN];
	assign speed   = first_setup_register_reg[`CC_FIRST_SETUP_REGISTER_SPEED];
	assign core_rst = hw_rst | cfg_reg[`CC_CFG_SRST];
	assign mapped  = (paddr == `CC_CFG_OFS) | (paddr == `CC_FIRST_SETUP_REGISTER_OFS) |
		(paddr == `CC_NID_OFS) | (paddr == `CC_CMD_OFS) |
		(paddr == `CC_STAT_OFS) | (paddr == `CC_IMASK_OFS);
	assign rd_ok   = psel & ~penable & ~pwrite & mapped;
	assign cmd_wr  = wr & (paddr == `CC_CMD_OFS) & ~core_rst;
	assign cmd_page = pwdata[5:3];
	assign c_dis_tx = cmd_wr & (pwdata[2:0] == cc_pkg::CC_CMD_DIS_TX);
	assign c_dis_rx = cmd_wr & (pwdata[2:0] == cc_pkg::CC_CMD_DIS_RX);
	assign c_en_tx  = cmd_wr & (pwdata[2:0] == cc_pkg::CC_CMD_EN_TX);
	assign c_en_rx  = cmd_wr & (pwdata[2:0] == cc_pkg::CC_CMD_EN_RX);
	assign c_clr_tx = cmd_wr & (pwdata[2:0] == cc_pkg::CC_CMD_CLR_TX);
	assign c_clr_rx = cmd_wr & (pwdata[2:0] == cc_pkg::CC_CMD_CLR_RX);
	assign nid_wr   = wr & (paddr == `CC_NID_OFS) & ~core_rst & (pwdata[7:0] != 8'h00);
	assign tx_fin   = media.tx_done & tx_act_reg;
	assign rx_fin   = media.rx_done & rx_busy_reg;
	assign tx_go    = media.token_rx & txq_v_reg[0] & ~tx_act_reg & core_awake &
		cfg_reg[`CC_CFG_TXEN];
	assign rx_go    = media.rx_start & rxq_v_reg[0] & ~rx_busy_reg & core_awake;
	assign rd_data  =
		(paddr == `CC_CFG_OFS)    ? {24'h0, cfg_reg} :
		(paddr == `CC_FIRST_SETUP_REGISTER_OFS) ? {24'h0, first_setup_register_reg} :
		(paddr == `CC_NID_OFS)    ? {24'h0, nid_reg} :
		(paddr == `CC_IMASK_OFS)  ? {30'h0, imask_reg} :
		(paddr == `CC_STAT_OFS)   ? {21'h0, rxr_p_reg[0], txq_v_reg, core_awake,
			rxr_v_reg[0], ~rxq_v_reg[0], txr_v_reg[0], chain ? txr_a_reg[0] : tma_reg,
			ta_reg} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= rd_ok ? rd_data : 32'h0;
		end
	end

	// configuration and setup survive soft reset, only presetn and the pin filter clear them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg    <= `CC_CFG_RST;
			first_setup_register_reg <= `CC_FIRST_SETUP_REGISTER_RST;
		end else if (hw_rst) begin
			cfg_reg    <= `CC_CFG_RST;
			first_setup_register_reg <= `CC_FIRST_SETUP_REGISTER_RST;
		end else begin
			if (wr && paddr == `CC_CFG_OFS)
				cfg_reg <= pwdata[7:0];
			if (wr && paddr == `CC_FIRST_SETUP_REGISTER_OFS)
				first_setup_register_reg <= pwdata[7:0];
		end
	end

	// transmit queue and double-buffered results
	always_comb begin
		txq_v_next    = txq_v_reg;
		txq_p_next    = txq_p_reg;
		tx_act_next   = tx_act_reg;
		txr_v_next    = c_clr_tx ? {1'b0, txr_v_reg[1]} : txr_v_reg;
		txr_a_next    = c_clr_tx ? {1'b0, txr_a_reg[1]} : txr_a_reg;
		tma_next      = tma_reg;
		tx_start_next = 1'b0;
		if (tx_fin) begin
			tma_next = media.tx_ack;
			if (txr_v_next[0]) begin
				txr_v_next[1] = 1'b1;
				txr_a_next[1] = media.tx_ack;
			end else begin
				txr_v_next[0] = 1'b1;
				txr_a_next[0] = media.tx_ack;
			end
		end
		if (tx_fin || c_dis_tx) begin
			txq_v_next    = {1'b0, txq_v_reg[1]};
			txq_p_next[0] = txq_p_reg[1];
			tx_act_next   = 1'b0;
		end
		if (c_en_tx) begin
			if (!txq_v_next[0]) begin
				txq_v_next[0] = 1'b1;
				txq_p_next[0] = cmd_page;
				tma_next      = 1'b0;
			end else if (chain && !txq_v_next[1]) begin
				txq_v_next[1] = 1'b1;
				txq_p_next[1] = cmd_page;
			end
		end
		if (tx_go) begin
			tx_act_next   = 1'b1;
			tx_start_next = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txq_v_reg  <= 2'h0;
			txq_p_reg  <= '{3'h0, 3'h0};
			tx_act_reg <= 1'b0;
			txr_v_reg  <= 2'h0;
			txr_a_reg  <= 2'h0;
			tma_reg    <= 1'b0;
			ta_reg     <= 1'b1;
			tx_start   <= 1'b0;
			tx_page    <= 3'h0;
			tx_enable  <= 1'b0;
		end else if (core_rst) begin
			txq_v_reg  <= 2'h0;
			tx_act_reg <= 1'b0;
			txr_v_reg  <= 2'h0;
			txr_a_reg  <= 2'h0;
			tma_reg    <= 1'b0;
			ta_reg     <= 1'b1;
			tx_start   <= 1'b0;
			tx_enable  <= 1'b0;
		end else begin
			txq_v_reg  <= txq_v_next;
			txq_p_reg  <= txq_p_next;
			tx_act_reg <= tx_act_next;
			txr_v_reg  <= txr_v_next;
			txr_a_reg  <= txr_a_next;
			tma_reg    <= tma_next;
			ta_reg     <= ~txq_v_next[0];
			tx_start   <= tx_start_next;
			tx_page    <= tx_go ? txq_p_reg[0] : tx_page;
			tx_enable  <= cfg_reg[`CC_CFG_TXEN];
		end
	end
	property p_nonchain_single;
		!chain |-> !txq_v_reg[1] || $past(chain);
	endproperty
	a_nonchain_single: assert property (p_nonchain_single) else $error("queue grew");
	property p_en_clears;
		c_en_tx && !txq_v_reg[0] && !tx_fin |=> !ta_reg && !tma_reg;
	endproperty
	a_en_clears: assert property (p_en_clears) else $error("flags not cleared");
	property p_second_q;
		c_en_tx && chain && txq_v_reg == 2'h1 && !tx_fin && !c_dis_tx
			|=> txq_v_reg[1] && txq_p_reg[1] == $past(cmd_page);
	endproperty
	a_second_q: assert property (p_second_q) else $error("second not queued");
	property p_done_sets;
		tx_fin && !c_clr_tx |=> txr_v_reg[0];
	endproperty
	a_done_sets: assert property (p_done_sets) else $error("done event missing");
	property p_status_held;
		txr_v_reg[0] && !c_clr_tx |=> txr_v_reg[0] && txr_a_reg[0] == $past(txr_a_reg[0]);
	endproperty
	a_status_held: assert property (p_status_held) else $error("status lost");
	property p_auto_start;
		tx_go |=> tx_start && tx_page == $past(txq_p_reg[0]) ##1 !tx_start;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("no start");
	property p_full_ignore;
		c_en_tx && txq_v_reg == 2'h3 && !tx_fin |=> txq_p_reg[1] == $past(txq_p_reg[1]);
	endproperty
	a_full_ignore: assert property (p_full_ignore) else $error("full queue changed");

	// receive queue; a reception already under way cannot be withdrawn
	always_comb begin
		rxq_v_next   = rxq_v_reg;
		rxq_p_next   = rxq_p_reg;
		rx_busy_next = rx_busy_reg;
		rxr_v_next   = c_clr_rx ? {1'b0, rxr_v_reg[1]} : rxr_v_reg;
		rxr_p_next[0] = c_clr_rx ? rxr_p_reg[1] : rxr_p_reg[0];
		rxr_p_next[1] = rxr_p_reg[1];
		if (rx_fin) begin
			if (rxr_v_next[0]) begin
				rxr_v_next[1] = 1'b1;
				rxr_p_next[1] = rxq_p_reg[0];
			end else begin
				rxr_v_next[0] = 1'b1;
				rxr_p_next[0] = rxq_p_reg[0];
			end
		end
		if (rx_fin || (c_dis_rx && !rx_busy_reg)) begin
			rxq_v_next    = {1'b0, rxq_v_reg[1]};
			rxq_p_next[0] = rxq_p_reg[1];
			rx_busy_next  = 1'b0;
		end
		if (c_en_rx) begin
			if (!rxq_v_next[0]) begin
				rxq_v_next[0] = 1'b1;
				rxq_p_next[0] = cmd_page;
			end else if (chain && !rxq_v_next[1]) begin
				rxq_v_next[1] = 1'b1;
				rxq_p_next[1] = cmd_page;
			end
		end
		if (rx_go)
			rx_busy_next = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxq_v_reg   <= 2'h0;
			rxq_p_reg   <= '{3'h0, 3'h0};
			rx_busy_reg <= 1'b0;
			rxr_v_reg   <= 2'h0;
			rxr_p_reg   <= '{3'h0, 3'h0};
			rx_arm      <= 1'b0;
			rx_page     <= 3'h0;
		end else if (core_rst) begin
			rxq_v_reg   <= 2'h0;
			rx_busy_reg <= 1'b0;
			rxr_v_reg   <= 2'h0;
			rx_arm      <= 1'b0;
		end else begin
			rxq_v_reg   <= rxq_v_next;
			rxq_p_reg   <= rxq_p_next;
			rx_busy_reg <= rx_busy_next;
			rxr_v_reg   <= rxr_v_next;
			rxr_p_reg   <= rxr_p_next;
			rx_arm      <= rxq_v_next[0];
			rx_page     <= rxq_p_next[0];
		end
	end
	property p_rx_keep;
		c_dis_rx && rx_busy_reg && !rx_fin && !c_en_rx |=> rxq_v_reg == $past(rxq_v_reg);
	endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("busy rx cancelled");

	// interrupt: any clear drops the line so the next event shows as a new edge
	assign pend = chain ?
		((txr_v_reg[0] & imask_reg[0]) | (rxr_v_reg[0] & imask_reg[1])) :
		((ta_reg & imask_reg[0]) | (~rxq_v_reg[0] & imask_reg[1]));
	assign irq_next = pend & (gap_reg == 7'h0) & ~c_clr_tx & ~c_clr_rx;
	assign gap_load = speed ? 7'(`CC_GAP_CYC) : 7'(2 * `CC_GAP_CYC);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq       <= 1'b0;
			gap_reg   <= 7'h0;
			imask_reg <= `CC_IMASK_RST;
		end else if (core_rst) begin
			irq       <= 1'b0;
			gap_reg   <= 7'h0;
			imask_reg <= `CC_IMASK_RST;
		end else begin
			irq       <= irq_next;
			gap_reg   <= (irq && !irq_next) ? gap_load :
				(gap_reg != 7'h0) ? gap_reg - 7'h1 : 7'h0;
			if (wr && paddr == `CC_IMASK_OFS)
				imask_reg <= pwdata[1:0];
		end
	end
	property p_irq_gap;
		$fell(irq) && speed |-> !irq [*8] ##1 (gap_reg != 7'h0);
	endproperty
	a_irq_gap: assert property (p_irq_gap) else $error("gap too short");

	// node identifier wake-up and the two buffer writes
	always_comb begin
		ram_st_next = ram_st_reg;
		unique case (ram_st_reg)
			cc_pkg::CC_RAM_IDLE: if (nid_wr) ram_st_next = cc_pkg::CC_RAM_WR0;
			cc_pkg::CC_RAM_WR0:  ram_st_next = cc_pkg::CC_RAM_WR1;
			cc_pkg::CC_RAM_WR1:  ram_st_next = cc_pkg::CC_RAM_IDLE;
			default:             ram_st_next = cc_pkg::CC_RAM_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_st_reg <= cc_pkg::CC_RAM_IDLE;
			nid_reg    <= 8'h00;
			core_awake <= 1'b0;
			ram_we     <= 1'b0;
			ram_addr   <= 11'h000;
			ram_wdata  <= 8'h00;
		end else if (core_rst) begin
			ram_st_reg <= cc_pkg::CC_RAM_IDLE;
			nid_reg    <= 8'h00;
			core_awake <= 1'b0;
			ram_we     <= 1'b0;
		end else begin
			ram_st_reg <= ram_st_next;
			if (wr && paddr == `CC_NID_OFS)
				nid_reg <= pwdata[7:0];
			core_awake <= core_awake | nid_wr;
			ram_we     <= (ram_st_next != cc_pkg::CC_RAM_IDLE);
			ram_addr   <= (ram_st_next == cc_pkg::CC_RAM_WR1) ? 11'h001 : 11'h000;
			ram_wdata  <= (ram_st_next == cc_pkg::CC_RAM_WR1) ? nid_reg : `CC_CHECK_PATTERN;
		end
	end

	sequence s_ram_pat;
		ram_we && ram_addr == 11'h000 && ram_wdata == `CC_CHECK_PATTERN;
	endsequence
	sequence s_ram_nid;
		ram_we && ram_addr == 11'h001 && ram_wdata == nid_reg;
	endsequence
	property p_nid_seq;
		nid_wr && ram_st_reg == cc_pkg::CC_RAM_IDLE |=> s_ram_pat ##1 s_ram_nid ##1 !ram_we;
	endproperty
	a_nid_seq: assert property (p_nid_seq) else $error("ram writes wrong");
endmodule : cc_chain
`default_nettype wire

// *** sim/cc_media_model.sv ***
// behavioural media engine facing the chaining block
`timescale 1ns/1ps
`default_nettype none
module cc_media_model (
	// clock
	input  wire logic              pclk,
	// from the block
	input  wire logic              tx_start,
	input  wire logic [2:0]        tx_page,
	// strobes to the block
	output var  cc_pkg::cc_media_s media
);
	// reply delay in cycles; raise it to model a slow far side
	int lag = 3;
	initial media = '0;
	// one-cycle pulse on strobe bit b
	task automatic pulse(input int b);
		@(posedge pclk);
		media[b] <= 1'b1;
		@(posedge pclk);
		media[b] <= 1'b0;
	endtask : pulse
	// token pass; a started frame ends with the given ack
	task automatic token(input logic ack, output logic go, output logic [2:0] pg);
		int k;
		pulse(4);
		go = 1'b0;
		pg = 3'h0;
		for (k = 0; k < 8 && !go; k++) begin
			@(posedge pclk);
			go = (tx_start === 1'b1);
			pg = tx_page;
		end
		if (go) begin
			repeat (lag) @(posedge pclk);
			media.tx_ack <= ack;
			media.tx_done <= 1'b1;
			@(posedge pclk);
			media.tx_done <= 1'b0;
			// ack means nothing outside the strobe, so show its inverse
			media.tx_ack <= ~ack;
		end
	endtask : token
endmodule : cc_media_model
`default_nettype wire

// *** sim/cc_chain_tb.sv ***
// self-checking bench for the chaining block
`timescale 1ns/1ps
`default_nettype none
`include "cc_chain_map.svh"
module cc_chain_tb;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              hw_reset_n_input = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready, pslverr, tx_start, rx_arm, tx_enable;
	logic              core_awake, ram_we, irq, perr, go;
	logic [2:0]        tx_page, rx_page, pg;
	logic [10:0]       ram_addr;
	logic [7:0]        ram_wdata;
	logic [31:0]       rdat;
	logic [18:0]       ramq[$];
	cc_pkg::cc_media_s media;
	int                errors = 0;
	int                n_checks = 0;
	int                n;
	always #2.5 pclk = ~pclk;
	cc_chain cc_chain_i (
		.pclk(pclk), .presetn(presetn), .hw_reset_n_input(hw_reset_n_input),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.media(media), .tx_start(tx_start), .tx_page(tx_page), .rx_arm(rx_arm),
		.rx_page(rx_page), .tx_enable(tx_enable), .core_awake(core_awake),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .irq(irq)
	);
	cc_media_model cc_media_model_i (
		.pclk(pclk), .tx_start(tx_start), .tx_page(tx_page), .media(media)
	);
	// buffer writes seen on the ram port
	always @(posedge pclk) if (ram_we === 1'b1) ramq.push_back({ram_addr, ram_wdata});
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask : tick
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed; the watchdog ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic cmd(input cc_pkg::cc_cmd_e op, input logic [2:0] p);
		wr(`CC_CMD_OFS, {26'h0, p, op});
	endtask : cmd
	// bounded wait for the interrupt line
	task automatic wait_irq(output int k);
		k = 0;
		while (irq !== 1'b1 && k < 400) begin
			@(posedge pclk);
			k++;
		end
	endtask : wait_irq
	task automatic t_reset;
		chk(tx_enable, 1'b0);
		chk(irq, 1'b0);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h3F, 32'h09);
		rd(`CC_CFG_OFS);
		chk(rdat[7:0], `CC_CFG_RST);
		rd(8'hFC);
		chk(perr, 1'b1);
		chk(rdat, 32'h0);
	endtask : t_reset
	task automatic t_nid;
		wr(`CC_FIRST_SETUP_REGISTER_OFS, 32'h1);
		wr(`CC_NID_OFS, 32'h0);
		tick(4);
		chk(ramq.size() + core_awake, 32'h0);
		wr(`CC_NID_OFS, 32'h5A);
		tick(4);
		chk(ramq.size(), 32'h2);
		chk(ramq[0], {11'h0, `CC_CHECK_PATTERN});
		chk(ramq[1], {11'h1, 8'h5A});
		chk(core_awake, 1'b1);
	endtask : t_nid
	task automatic t_tx;
		wr(`CC_CFG_OFS, 32'h60);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h2);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h3, 32'h0);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h3);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h5);
		cc_media_model_i.token(1'b1, go, pg);
		chk({go, pg}, 32'hA);
		tick(2);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h6, 32'h6);
		chk(irq, 1'b0);
		wr(`CC_IMASK_OFS, 32'h1);
		wait_irq(n);
		chk(irq, 1'b1);
		cc_media_model_i.token(1'b0, go, pg);
		chk({go, pg}, 32'hB);
		tick(2);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h6, 32'h6);
		chk(irq, 1'b1);
		cmd(cc_pkg::CC_CMD_CLR_TX, 3'h0);
		tick(2);
		chk(irq, 1'b0);
		wait_irq(n);
		chk({irq, n + 2 >= `CC_GAP_CYC}, 32'h3);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h6, 32'h4);
		cmd(cc_pkg::CC_CMD_CLR_TX, 3'h0);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h4, 32'h0);
		cc_media_model_i.token(1'b1, go, pg);
		chk(go, 1'b0);
	endtask : t_tx
	task automatic t_txdis;
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h1);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h4);
		cmd(cc_pkg::CC_CMD_DIS_TX, 3'h0);
		cc_media_model_i.token(1'b1, go, pg);
		chk({go, pg}, 32'hC);
		tick(2);
		cmd(cc_pkg::CC_CMD_CLR_TX, 3'h0);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h6);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h7);
		cmd(cc_pkg::CC_CMD_DIS_TX, 3'h0);
		cmd(cc_pkg::CC_CMD_DIS_TX, 3'h0);
		cc_media_model_i.token(1'b1, go, pg);
		chk(go, 1'b0);
	endtask : t_txdis
	task automatic t_rx;
		wr(`CC_IMASK_OFS, 32'h3);
		cmd(cc_pkg::CC_CMD_EN_RX, 3'h1);
		cmd(cc_pkg::CC_CMD_EN_RX, 3'h4);
		tick(2);
		chk({rx_arm, rx_page}, 32'h9);
		cc_media_model_i.pulse(1);
		// disable while busy must not touch the queue
		cmd(cc_pkg::CC_CMD_DIS_RX, 3'h0);
		cc_media_model_i.pulse(0);
		wait_irq(n);
		chk(irq, 1'b1);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h710, 32'h110);
		chk({rx_arm, rx_page}, 32'hC);
		cc_media_model_i.pulse(1);
		cc_media_model_i.pulse(0);
		tick(2);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h710, 32'h110);
		cmd(cc_pkg::CC_CMD_CLR_RX, 3'h0);
		tick(2);
		chk(irq, 1'b0);
		wait_irq(n);
		chk({irq, n + 2 >= `CC_GAP_CYC}, 32'h3);
		rd(`CC_STAT_OFS);
		chk(rdat & 32'h718, 32'h418);
		cmd(cc_pkg::CC_CMD_CLR_RX, 3'h0);
		cmd(cc_pkg::CC_CMD_EN_RX, 3'h2);
		cmd(cc_pkg::CC_CMD_EN_RX, 3'h3);
		cmd(cc_pkg::CC_CMD_DIS_RX, 3'h0);
		tick(2);
		chk({rx_arm, rx_page}, 32'hB);
		cmd(cc_pkg::CC_CMD_DIS_RX, 3'h0);
		tick(2);
		chk(rx_arm, 1'b0);
	endtask : t_rx
	task automatic t_srst;
		wr(`CC_CFG_OFS, 32'hE0);
		tick(2);
		chk(tx_enable, 1'b0);
		rd(`CC_CFG_OFS);
		chk(rdat[7:0], 8'hE0);
		rd(`CC_FIRST_SETUP_REGISTER_OFS);
		chk(rdat[7:0], 8'h01);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h1);
		wr(`CC_CFG_OFS, 32'h60);
		wr(`CC_NID_OFS, 32'h5A);
		tick(2);
		chk(tx_enable, 1'b1);
		cc_media_model_i.token(1'b1, go, pg);
		chk(go, 1'b0);
	endtask : t_srst
	task automatic t_hw;
		// four low samples sit just under the filter length
		hw_reset_n_input <= 1'b0;
		tick(4);
		hw_reset_n_input <= 1'b1;
		tick(12);
		rd(`CC_CFG_OFS);
		chk(rdat[7:0], 8'h60);
		hw_reset_n_input <= 1'b0;
		tick(16);
		chk(tx_enable, 1'b0);
		hw_reset_n_input <= 1'b1;
		tick(12);
		rd(`CC_CFG_OFS);
		chk(rdat[7:0], `CC_CFG_RST);
		rd(`CC_FIRST_SETUP_REGISTER_OFS);
		chk(rdat[7:0], `CC_FIRST_SETUP_REGISTER_RST);
	endtask : t_hw
	// plain mode after the pin reset: single queue, live flag interrupt, slow gap
	task automatic t_plain;
		wr(`CC_CFG_OFS, 32'h20);
		wr(`CC_NID_OFS, 32'h33);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h1);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h2);
		wr(`CC_IMASK_OFS, 32'h1);
		tick(2);
		chk(irq, 1'b0);
		cc_media_model_i.token(1'b1, go, pg);
		chk({go, pg}, 32'h9);
		wait_irq(n);
		chk(irq, 1'b1);
		cc_media_model_i.token(1'b1, go, pg);
		chk(go, 1'b0);
		cmd(cc_pkg::CC_CMD_EN_TX, 3'h3);
		cmd(cc_pkg::CC_CMD_DIS_TX, 3'h0);
		wait_irq(n);
		chk({irq, n + 2 >= 2 * `CC_GAP_CYC}, 32'h3);
	endtask : t_plain
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_nid;
		t_tx;
		t_txdis;
		t_rx;
		t_srst;
		t_hw;
		t_plain;
		give_verdict;
	end
	// the whole run needs well under a tenth of this span
	initial begin
		#200000;
		errors++;
		give_verdict;
	end
endmodule : cc_chain_tb
`default_nettype wire
